// ---- verilog/kti_consts.vh ----
`ifndef KTI_CONSTS_VH
`define KTI_CONSTS_VH
// ==========================================================
// Register map
`define KTI_FLAGS_ADDR      4'h0
`define KTI_EDGE_ADDR       4'h4
// ==========================================================
// Field positions in the flag register
`define KTI_BIT_KEY_EN      3
`define KTI_BIT_KEY_PEND    2
`define KTI_BIT_T1_EN       1
`define KTI_BIT_T1_PEND     0
// ==========================================================
// Reset values
`define KTI_FLAGS_RST       4'h0
`define KTI_EDGE_RST        1'h0
// ==========================================================
// AXI response codes
`define KTI_RESP_OKAY       2'h0
`define KTI_RESP_SLVERR     2'h2
`endif

// ---- verilog/kti_key_timer1_irq_flags.v ----
`timescale 1ns/1ns
`default_nettype none
`include "kti_consts.vh"
module kti_key_timer1_irq_flags #(
   parameter NKEYS = 8
) (
   input  wire             clock,
   input  wire             sys_rst,
   input  wire [NKEYS-1:0] key_input_pins,
   input  wire             timer1_event,
   input  wire             key_irq_ack,
   input  wire             timer1_irq_ack,
   output wire             key_pin_interrupt,
   output wire             timer1_interrupt,
   input  wire [3:0]       s_axi_awaddr,
   input  wire             s_axi_awvalid,
   output wire             s_axi_awready,
   input  wire [31:0]      s_axi_wdata,
   input  wire [3:0]       s_axi_wstrb,
   input  wire             s_axi_wvalid,
   output wire             s_axi_wready,
   output wire [1:0]       s_axi_bresp,
   output wire             s_axi_bvalid,
   input  wire             s_axi_bready,
   input  wire [3:0]       s_axi_araddr,
   input  wire             s_axi_arvalid,
   output wire             s_axi_arready,
   output wire [31:0]      s_axi_rdata,
   output wire [1:0]       s_axi_rresp,
   output wire             s_axi_rvalid,
   input  wire             s_axi_rready
);

   // ==========================================================
   // Storage
   reg [NKEYS-1:0] key_s1_r;      // First sync stage
   reg [NKEYS-1:0] key_s2_r;      // Second sync stage
   reg [NKEYS-1:0] key_d_r;       // Delayed for edge detect
   reg             key_irq_enable_r;
   reg             key_irq_pending_r;
   reg             timer1_irq_enable_r;
   reg             timer1_irq_pending_r;
   reg             edge_fall_r;   // 0 rising, 1 falling
   reg             aw_got_r;      // Write address held
   reg             w_got_r;       // Write data held
   reg [3:0]       awaddr_r;      // Captured write address
   reg [31:0]      wdata_r;       // Captured write data
   reg             wstrb0_r;      // Low lane strobe
   reg             bvalid_r;
   reg [1:0]       bresp_r;
   reg             rvalid_r;
   reg [1:0]       rresp_r;
   reg [31:0]      rdata_r;

   // ==========================================================
   // Word indexes of the two registers
   // Full byte addresses kept here so that the word index is a part-select
   // and no comparison has to widen or narrow a shifted macro
   localparam [3:0] FLG_ADDR = `KTI_FLAGS_ADDR; // Flag register
   localparam [3:0] EDG_ADDR = `KTI_EDGE_ADDR;  // Edge select register
   localparam [1:0] FLG_IDX  = FLG_ADDR[3:2];   // Flag word index
   localparam [1:0] EDG_IDX  = EDG_ADDR[3:2];   // Edge word index

   // ==========================================================
   // Edge detection on synchronised key pins
   // Only the second sync stage and its delayed copy feed this,
   // so a metastable first stage never reaches the flag
   wire [NKEYS-1:0] rise_w = key_s2_r & ~key_d_r;
   wire [NKEYS-1:0] fall_w = ~key_s2_r & key_d_r;
   wire key_edge_w = edge_fall_r ? (|fall_w) : (|rise_w);

   // ==========================================================
   // Write decode
   wire wr_go_w  = aw_got_r & w_got_r & ~bvalid_r;
   wire wr_flg_w = wr_go_w & wstrb0_r & (awaddr_r[3:2] == FLG_IDX);
   wire wr_edg_w = wr_go_w & wstrb0_r & (awaddr_r[3:2] == EDG_IDX);
   // Unmapped words answer with an error and change nothing
   wire wr_ok_w  = (awaddr_r[3:2] == FLG_IDX) ||
                   (awaddr_r[3:2] == EDG_IDX);

   assign s_axi_awready = ~aw_got_r;
   assign s_axi_wready  = ~w_got_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = ~rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;

   // ==========================================================
   // Interrupt outputs, flag and enable both set
   assign key_pin_interrupt = key_irq_enable_r & key_irq_pending_r;
   assign timer1_interrupt  = timer1_irq_enable_r & timer1_irq_pending_r;

   // ==========================================================
   // Key pin synchroniser and edge history
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         key_s1_r <= {NKEYS{1'b0}};
         key_s2_r <= {NKEYS{1'b0}};
         key_d_r  <= {NKEYS{1'b0}};
      end else begin
         key_s1_r <= key_input_pins;
         key_s2_r <= key_s1_r;
         key_d_r  <= key_s2_r;
      end
   end

   // ==========================================================
   // Flag register; hardware set wins over any clear
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         key_irq_enable_r     <= 1'b0;
         key_irq_pending_r    <= 1'b0;
         timer1_irq_enable_r  <= 1'b0;
         timer1_irq_pending_r <= 1'b0;
         edge_fall_r          <= `KTI_EDGE_RST;
      end else begin
         // Software writes first
         if (wr_flg_w) begin
            key_irq_enable_r     <= wdata_r[`KTI_BIT_KEY_EN];
            key_irq_pending_r    <= wdata_r[`KTI_BIT_KEY_PEND];
            timer1_irq_enable_r  <= wdata_r[`KTI_BIT_T1_EN];
            timer1_irq_pending_r <= wdata_r[`KTI_BIT_T1_PEND];
         end
         if (wr_edg_w) begin
            edge_fall_r <= wdata_r[0];
         end
         // Service acknowledge clears flag
         if (key_irq_ack) begin
            key_irq_pending_r <= 1'b0;
         end
         if (timer1_irq_ack) begin
            timer1_irq_pending_r <= 1'b0;
         end
         // Hardware events take priority
         if (key_edge_w) begin
            key_irq_pending_r <= 1'b1;
         end
         if (timer1_event) begin
            timer1_irq_pending_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // AXI write channel: capture AW and W in either order
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= 4'h0;
         wdata_r  <= 32'h0;
         wstrb0_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r  <= `KTI_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_got_r) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_got_r) begin
            w_got_r  <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb0_r <= s_axi_wstrb[0];
         end
         // Both halves present: answer
         if (wr_go_w) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_ok_w ? `KTI_RESP_OKAY : `KTI_RESP_SLVERR;
         end
         // Response taken: free both halves
         if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
         end
      end
   end

   // ==========================================================
   // AXI read channel: one cycle after address
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rvalid_r <= 1'b0;
         rresp_r  <= `KTI_RESP_OKAY;
         rdata_r  <= 32'h0;
      end else begin
         if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            case (s_axi_araddr[3:2])
               FLG_IDX: begin
                  rdata_r <= {28'h0, key_irq_enable_r, key_irq_pending_r,
                              timer1_irq_enable_r, timer1_irq_pending_r};
                  rresp_r <= `KTI_RESP_OKAY;
               end
               EDG_IDX: begin
                  rdata_r <= {31'h0, edge_fall_r};
                  rresp_r <= `KTI_RESP_OKAY;
               end
               default: begin
                  rdata_r <= 32'h0;
                  rresp_r <= `KTI_RESP_SLVERR;
               end
            endcase
         end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ---- dv/kti_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Flag register checker
module kti_monitor #(
   parameter NKEYS = 8
) (
   input wire logic             clock,
   input wire logic             sys_rst,
   input wire logic [NKEYS-1:0] key_input_pins,
   input wire logic             timer1_event,
   input wire logic             key_irq_ack,
   input wire logic             timer1_irq_ack,
   input wire logic             key_pin_interrupt,
   input wire logic             timer1_interrupt,
   input wire logic             s_axi_wvalid,
   input wire logic             s_axi_bvalid,
   input wire logic             s_axi_arvalid,
   input wire logic             s_axi_arready,
   input wire logic             s_axi_rvalid
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // Interrupt rises only from its own cause or a write
   // A write lands at the edge where bvalid rises, so bvalid stands when the rise is seen
   key_cause_a: assert property ($rose(key_pin_interrupt) |->
      $past(key_input_pins, 3) != $past(key_input_pins, 4) || s_axi_bvalid)
      else $error("key interrupt rose without cause");
   timer_cause_a: assert property ($rose(timer1_interrupt) |->
      $past(timer1_event) || s_axi_bvalid) else $error("timer interrupt rose without cause");
   key_clear_a: assert property (key_irq_ack && !s_axi_wvalid && !s_axi_bvalid &&
      !$past(s_axi_wvalid) && key_input_pins == $past(key_input_pins, 3)
      |=> !key_pin_interrupt) else $error("key flag not cleared");
   timer_clear_a: assert property (timer1_irq_ack && !timer1_event && !s_axi_wvalid &&
      !s_axi_bvalid |=> !timer1_interrupt) else $error("timer flag not cleared");
   timer_hold_a: assert property (timer1_interrupt && !timer1_irq_ack && !s_axi_wvalid &&
      !s_axi_bvalid && !$past(s_axi_wvalid) |=> timer1_interrupt)
      else $error("timer interrupt dropped");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   cover property ($rose(key_pin_interrupt));
   cover property ($rose(timer1_interrupt));
   cover property (key_irq_ack);
endmodule
bind kti_key_timer1_irq_flags kti_monitor #(.NKEYS(NKEYS)) i_mon (.*);
`default_nettype wire

// ---- dv/kti_cpu_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Processor side: services a presented request once
module kti_cpu_model (
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic       serve,
   input  wire logic [1:0] irq,
   output var logic  [1:0] ack
);
   // One-cycle acknowledge, only while servicing is allowed
   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst)
         ack <= 2'h0;
      else
         ack <= serve ? irq & ~ack : 2'h0;
   end
endmodule
`default_nettype wire

// ---- dv/kti_key_timer1_irq_flags_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "kti_consts.vh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; \
   $display("wrong value %s exp %h got %h", n, e, s); end end
module kti_key_timer1_irq_flags_bench;
   logic        clock = 0, sys_rst = 1, timer1_event = 0, serve = 0;
   logic [7:0]  key_input_pins = 8'h0;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   wire         key_irq_ack, timer1_irq_ack, key_pin_interrupt, timer1_interrupt;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]   s_axi_bresp, s_axi_rresp;
   wire [31:0]  s_axi_rdata;
   int          n_fail = 0, compares = 0;
   always #5 clock = ~clock;
   kti_key_timer1_irq_flags i_dut (.*);
   kti_cpu_model i_cpu (.clock(clock), .sys_rst(sys_rst), .serve(serve),
      .irq({key_pin_interrupt, timer1_interrupt}), .ack({key_irq_ack, timer1_irq_ack}));
   // ==========================================
   // Bus tasks
   task automatic wr(input [3:0] a, input [31:0] d, input [1:0] er);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
      `CHK("bresp", er, s_axi_bresp)
   endtask
   task automatic rd(input [3:0] a, input [31:0] ed, input [1:0] er);
      @(posedge clock);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
      `CHK("rdata", ed, s_axi_rdata)
      `CHK("rresp", er, s_axi_rresp)
   endtask
   // Interrupt pair {key, timer} after k edges
   task automatic irq(input int k, input [1:0] e);
      repeat (k) @(posedge clock);
      #1;
      `CHK("irq", e, {key_pin_interrupt, timer1_interrupt})
      @(posedge clock);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_timer;
      rd(`KTI_FLAGS_ADDR, 32'h0, 2'h0);
      wr(`KTI_FLAGS_ADDR, 32'h2, 2'h0);
      timer1_event <= 1;
      @(posedge clock);
      timer1_event <= 0;
      irq(2, 2'h1);
      rd(`KTI_FLAGS_ADDR, 32'h3, 2'h0);
      wr(`KTI_FLAGS_ADDR, 32'h1, 2'h0);
      irq(1, 2'h0);
      wr(`KTI_FLAGS_ADDR, 32'h3, 2'h0);
      serve <= 1;
      irq(4, 2'h0);
      rd(`KTI_FLAGS_ADDR, 32'h2, 2'h0);
      serve <= 0;
   endtask
   task automatic t_key;
      wr(`KTI_FLAGS_ADDR, 32'h8, 2'h0);
      key_input_pins <= 8'h20;
      irq(5, 2'h2);
      rd(`KTI_FLAGS_ADDR, 32'hc, 2'h0);
      wr(`KTI_FLAGS_ADDR, 32'h4, 2'h0);
      irq(1, 2'h0);
      serve <= 1;
      wr(`KTI_FLAGS_ADDR, 32'hc, 2'h0);
      irq(4, 2'h0);
      rd(`KTI_FLAGS_ADDR, 32'h8, 2'h0);
      serve <= 0;
      key_input_pins <= 8'h0;
      irq(5, 2'h0);
      rd(`KTI_FLAGS_ADDR, 32'h8, 2'h0);
      // Falling edge mode: rise ignored, fall sets the flag
      wr(`KTI_EDGE_ADDR, 32'h1, 2'h0);
      rd(`KTI_EDGE_ADDR, 32'h1, 2'h0);
      key_input_pins <= 8'h01;
      irq(5, 2'h0);
      key_input_pins <= 8'h00;
      irq(5, 2'h2);
   endtask
   task automatic t_sw;
      wr(`KTI_FLAGS_ADDR, 32'hf, 2'h0);
      rd(`KTI_FLAGS_ADDR, 32'hf, 2'h0);
      irq(1, 2'h3);
      wr(4'h8, 32'h0, `KTI_RESP_SLVERR);
      rd(4'hc, 32'h0, `KTI_RESP_SLVERR);
      rd(`KTI_FLAGS_ADDR, 32'hf, 2'h0);
   endtask
   task automatic wrap_up;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clock);
      sys_rst <= 0;
      t_timer;
      t_key;
      t_sw;
      wrap_up;
   end
   // Watchdog against a hung handshake
   initial begin
      #100000;
      n_fail++;
      wrap_up;
   end
endmodule
`default_nettype wire
